// File: rtl/cfg_port_pkg.sv
// Constants shared by both ends of the configuration serial port.
// Assumes one 20 MHz clock and an asynchronous active-low reset on each end.
package cfg_port_pkg;
    // --------------------------------------------------------------
    // Bus addresses and layout
    // --------------------------------------------------------------
    localparam logic [7:0] WR_ADDR    = 8'hD2;
    localparam logic [7:0] RD_ADDR    = 8'hD3;
    localparam int         NUM_BYTES  = 8;
    localparam logic [7:0] BYTE_COUNT = 8'h08;
    localparam logic [7:0] DUMMY_CMD  = 8'h00;
    // Power-on defaults of configuration bytes 0..7 (plain values)
    localparam logic [63:0] CFG_RESET = 64'h0000_0000_0000_0000;
    // --------------------------------------------------------------
    // Timing
    // --------------------------------------------------------------
    localparam int CLK_NS      = 50;
    localparam int BIT_RATE_KB = 100;
    // Quarter bit period, rounded up so the rate stays at or below 100 kbit/s
    localparam int QTR_NS      = 1000000 / (BIT_RATE_KB * 4);
    localparam int QTR_CYC     = (QTR_NS + CLK_NS - 1) / CLK_NS;
    localparam int QTR_W       = 8;
    localparam logic [QTR_W-1:0] QTR_LAST = QTR_W'(QTR_CYC - 1);
endpackage

// File: rtl/cfg_port_if.sv
// Two-wire bus joining host and clock generator port.
// Both wires are open drain: a party pulls low when its enable is high.
interface cfg_port_if;
    logic scl_host_oe;
    logic sda_host_oe;
    logic sda_dev_oe;
    logic scl;
    logic sda;
    // Wired-AND of the open-drain drivers, pulled up when released
    assign scl = ~scl_host_oe;
    assign sda = ~(sda_host_oe | sda_dev_oe);
    modport host (output scl_host_oe, output sda_host_oe, input scl, input sda);
    modport dev  (output sda_dev_oe, input scl, input sda);
endinterface

// File: rtl/cfg_port_dev.sv
// Clock generator end of the configuration port: a two-wire slave that
// loads and reads back eight configuration bytes by block transfers.
// Assumes the host keeps standard-mode timing; bus lines are asynchronous
// to CLK_IN and pass two flip-flops before use.
//
// Contract
// - Write starts with address D2, acknowledged
// - Command and count bytes acknowledged, then dropped
// - Each written data byte acknowledged, from byte 0
// - Bytes in ascending order, stop after any
// - Data loads successive registers until stop
// - Host programs only with block writes
// - Read starts with address D3, acknowledged
// - Device sends count then bytes 0..7
// - Host acknowledges every read byte, then stops
// - Read-back returns current latch values
// - Host keeps rate at 100 kbit/s
// - Registers take defaults at power-on
module cfg_port_dev (
    input  wire logic        CLK_IN,
    input  wire logic        NRST_IN,
    cfg_port_if.dev          BUS,
    output logic [63:0]      CFG_OUT,
    output logic             WR_STROBE_OUT
);
    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_ADDR = 3'b001,
        S_RX   = 3'b010,
        S_ACK  = 3'b011,
        S_TX   = 3'b100,
        S_MACK  = 3'b101,
        S_SETUP = 3'b110
    } dstate_t;

    // ------------------------------------------------------------------
    // Synchronisers and edge detection
    // ------------------------------------------------------------------
    logic [1:0] scl_sync_q, sda_sync_q;
    logic       scl_prev_q, sda_prev_q;
    logic       scl_s, sda_s, scl_rise, scl_fall, start_ev, stop_ev;

    // Two stages per line, then one history bit for edges
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_sync_q <= {scl_sync_q[0], BUS.scl};
            sda_sync_q <= {sda_sync_q[0], BUS.sda};
            scl_prev_q <= scl_sync_q[1];
            sda_prev_q <= sda_sync_q[1];
        end
    end

    // Start and stop are data edges while the clock is high
    always_comb begin
        scl_s    = scl_sync_q[1];
        sda_s    = sda_sync_q[1];
        scl_rise = scl_s & ~scl_prev_q;
        scl_fall = ~scl_s & scl_prev_q;
        start_ev = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
        stop_ev  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
    end

    // ------------------------------------------------------------------
    // Protocol engine
    // ------------------------------------------------------------------
    dstate_t     state_q, state_d;
    logic [7:0]  shift_q, shift_d;
    logic [2:0]  bit_q, bit_d;
    logic [3:0]  idx_q, idx_d;      // 0 addr, 1 cmd, 2 count, 3.. data
    logic        rd_q, rd_d;
    logic        oe_q, oe_d;
    logic [63:0] cfg_q, cfg_d;
    logic        stb_q, stb_d;

    // Byte to send for read position n: count first, then bytes 0..7
    function automatic logic [7:0] tx_byte(input logic [3:0] n, input logic [63:0] c);
        logic [7:0] b;
        b = cfg_port_pkg::BYTE_COUNT;
        if (n != 4'h0) begin
            b = c[8*(n-4'h1) +: 8];
        end
        return b;
    endfunction

    // Next-state logic; SDA changes only after SCL falls
    always_comb begin
        state_d = state_q;
        shift_d = shift_q;
        bit_d   = bit_q;
        idx_d   = idx_q;
        rd_d    = rd_q;
        oe_d    = oe_q;
        cfg_d   = cfg_q;
        stb_d   = 1'b0;
        if (stop_ev) begin
            state_d = S_IDLE;
            oe_d    = 1'b0;
        end else if (start_ev) begin
            // Wait out the clock fall that closes the start
            state_d = S_SETUP;
            bit_d   = 3'h0;
            oe_d    = 1'b0;
        end else begin
            case (state_q)
                S_IDLE: begin
                    oe_d = 1'b0;
                end
                S_SETUP: begin
                    // That fall opens bit 7, so it must not be counted
                    if (scl_fall) begin
                        bit_d   = 3'h0;
                        state_d = S_ADDR;
                    end
                end
                S_ADDR, S_RX: begin
                    if (scl_rise) begin
                        shift_d = {shift_q[6:0], sda_s};
                    end
                    if (scl_fall) begin
                        bit_d = bit_q + 3'h1;
                        if (bit_q == 3'h7) begin
                            if (state_q == S_ADDR) begin
                                idx_d = 4'h0;
                                if (shift_q == cfg_port_pkg::WR_ADDR) begin
                                    rd_d = 1'b0;
                                    oe_d = 1'b1;
                                    state_d = S_ACK;
                                end else if (shift_q == cfg_port_pkg::RD_ADDR) begin
                                    rd_d = 1'b1;
                                    oe_d = 1'b1;
                                    state_d = S_ACK;
                                end else begin
                                    state_d = S_IDLE;
                                end
                            end else begin
                                oe_d    = 1'b1;
                                state_d = S_ACK;
                                if (idx_q >= 4'h3 && idx_q <= 4'hA) begin
                                    cfg_d[8*(idx_q-4'h3) +: 8] = shift_q;
                                    stb_d = 1'b1;
                                end
                            end
                        end
                    end
                end
                S_ACK: begin
                    if (scl_fall) begin
                        bit_d = 3'h0;
                        if (rd_q) begin
                            shift_d = tx_byte(4'h0, cfg_q);
                            oe_d    = ~cfg_port_pkg::BYTE_COUNT[7];
                            idx_d   = 4'h1;
                            state_d = S_TX;
                        end else begin
                            oe_d    = 1'b0;
                            idx_d   = (idx_q == 4'hF) ? idx_q : idx_q + 4'h1;
                            state_d = S_RX;
                        end
                    end
                end
                S_TX: begin
                    if (scl_fall) begin
                        bit_d = bit_q + 3'h1;
                        if (bit_q == 3'h7) begin
                            oe_d    = 1'b0;
                            state_d = S_MACK;
                        end else begin
                            shift_d = {shift_q[6:0], 1'b0};
                            oe_d    = ~shift_q[6];
                        end
                    end
                end
                S_MACK: begin
                    if (scl_rise && sda_s) begin
                        state_d = S_IDLE;
                    end else if (scl_fall) begin
                        bit_d = 3'h0;
                        if (idx_q >= 4'h9) begin
                            // Line left free so the host can send its stop
                            oe_d    = 1'b0;
                            state_d = S_IDLE;
                        end else begin
                            shift_d = tx_byte(idx_q, cfg_q);
                            oe_d    = ~shift_d[7];
                            idx_d   = idx_q + 4'h1;
                            state_d = S_TX;
                        end
                    end
                end
                default: begin
                    state_d = S_IDLE;
                    oe_d    = 1'b0;
                end
            endcase
        end
    end

    // State registers
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            state_q <= S_IDLE;
            shift_q <= 8'h00;
            bit_q   <= 3'h0;
            idx_q   <= 4'h0;
            rd_q    <= 1'b0;
            oe_q    <= 1'b0;
            cfg_q   <= cfg_port_pkg::CFG_RESET;
            stb_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            shift_q <= shift_d;
            bit_q   <= bit_d;
            idx_q   <= idx_d;
            rd_q    <= rd_d;
            oe_q    <= oe_d;
            cfg_q   <= cfg_d;
            stb_q   <= stb_d;
        end
    end

    assign BUS.sda_dev_oe = oe_q;
    assign CFG_OUT        = cfg_q;
    assign WR_STROBE_OUT  = stb_q;
endmodule

// File: rtl/cfg_port_host.sv
// Host end: a two-wire master that block-writes the first 1..8 or block-reads all eight
// configuration bytes of the clock generator.
// Assumes the device is the only slave; the SDA input passes two flip-flops.
module cfg_port_host (
    input  wire logic        CLK_IN,
    input  wire logic        NRST_IN,
    cfg_port_if.host         BUS,
    input  wire logic        GO_IN,
    input  wire logic        READ_IN,
    input  wire logic [3:0]  LEN_IN,
    input  wire logic [63:0] WDATA_IN,
    output logic             BUSY_OUT,
    output logic             DONE_OUT,
    output logic             NACK_OUT,
    output logic [63:0]      RDATA_OUT
);
    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        H_IDLE  = 3'b000,
        H_START = 3'b001,
        H_BIT   = 3'b010,
        H_STOP  = 3'b011,
        H_END   = 3'b100
    } hstate_t;

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    logic [1:0] sda_sync_q;
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            sda_sync_q <= 2'h3;
        end else begin
            sda_sync_q <= {sda_sync_q[0], BUS.sda};
        end
    end

    // ------------------------------------------------------------------
    // Bit engine: four quarter periods per bit, 9 bits per byte
    // ------------------------------------------------------------------
    hstate_t      state_q, state_d;
    logic [7:0]   qcnt_q, qcnt_d;
    logic [1:0]   ph_q, ph_d;
    logic [3:0]   bit_q, bit_d;   // 0..7 data, 8 ack slot
    logic [3:0]   pos_q, pos_d;   // byte position in frame
    logic [3:0]   last_q, last_d;
    logic         rd_q, rd_d;
    logic [8:0]   sh_q, sh_d;     // 8 data + ack
    logic         scl_oe_q, scl_oe_d, sda_oe_q, sda_oe_d;
    logic         done_q, done_d, nack_q, nack_d;
    logic [63:0]  wbuf_q, wbuf_d, rbuf_q, rbuf_d;
    logic         tick;

    // Byte the host drives at a position; reads drive only the address
    // block write layout only
    function automatic logic [7:0] host_byte(input logic [3:0] p, input logic rd,
                                             input logic [63:0] w);
        logic [7:0] b;
        b = 8'hFF;
        if (p == 4'h0) begin
            b = rd ? cfg_port_pkg::RD_ADDR : cfg_port_pkg::WR_ADDR;
        end else if (!rd && (p == 4'h1 || p == 4'h2)) begin
            b = (p == 4'h1) ? cfg_port_pkg::DUMMY_CMD : cfg_port_pkg::BYTE_COUNT;
        end else if (!rd) begin
            b = w[8*(p-4'h3) +: 8];
        end
        return b;
    endfunction

    always_comb begin
        tick     = (qcnt_q == cfg_port_pkg::QTR_LAST);
        state_d  = state_q;
        qcnt_d   = tick ? 8'h00 : qcnt_q + 8'h01;
        ph_d     = ph_q;
        bit_d    = bit_q;
        pos_d    = pos_q;
        last_d   = last_q;
        rd_d     = rd_q;
        sh_d     = sh_q;
        scl_oe_d = scl_oe_q;
        sda_oe_d = sda_oe_q;
        done_d   = 1'b0;
        nack_d   = nack_q;
        wbuf_d   = wbuf_q;
        rbuf_d   = rbuf_q;
        case (state_q)
            H_IDLE: begin
                qcnt_d = 8'h00;
                if (GO_IN) begin
                    rd_d     = READ_IN;
                    // Write length 1..8, 0 or over 8 writes all eight; read always fetches all
                    last_d   = READ_IN ? 4'h9 : ((LEN_IN == 4'h0 || LEN_IN > 4'h8) ? 4'hA : LEN_IN + 4'h2);
                    wbuf_d   = WDATA_IN;
                    nack_d   = 1'b0;
                    pos_d    = 4'h0;
                    state_d  = H_START;
                    sda_oe_d = 1'b1;
                end
            end
            H_START: begin
                if (tick) begin
                    scl_oe_d = 1'b1;
                    ph_d     = 2'h0;
                    bit_d    = 4'h0;
                    sh_d     = {host_byte(4'h0, rd_q, wbuf_q), 1'b1};
                    state_d  = H_BIT;
                end
            end
            H_BIT: begin
                if (tick) begin
                    ph_d = ph_q + 2'h1;
                    case (ph_q)
                        2'h0: sda_oe_d = ~sh_q[8];
                        2'h1: scl_oe_d = 1'b0;
                        2'h2: begin
                            sh_d = {sh_q[7:0], sda_sync_q[1]};
                        end
                        default: begin
                            scl_oe_d = 1'b1;
                            bit_d    = bit_q + 4'h1;
                            if (bit_q == 4'h8) begin
                                bit_d = 4'h0;
                                if (rd_q && pos_q != 4'h0) begin
                                    if (pos_q >= 4'h2) begin
                                        rbuf_d[8*(pos_q-4'h2) +: 8] = sh_q[8:1];
                                    end
                                end else if (sh_q[0]) begin
                                    nack_d = 1'b1;
                                end
                                if (pos_q == last_q || (sh_q[0] && !(rd_q && pos_q != 4'h0))) begin
                                    sda_oe_d = 1'b1;
                                    state_d  = H_STOP;
                                end else begin
                                    pos_d = pos_q + 4'h1;
                                    sh_d  = {host_byte(pos_q + 4'h1, rd_q, wbuf_q), 1'b1};
                                end
                            end else if (bit_q == 4'h7) begin
                                // Ack slot: host acks every read byte, else releases
                                // ack every read byte
                                sh_d = {(rd_q && pos_q != 4'h0) ? 1'b0 : 1'b1, sh_q[7:0]};
                            end
                        end
                    endcase
                end
            end
            H_STOP: begin
                if (tick) begin
                    ph_d = ph_q + 2'h1;
                    if (ph_q == 2'h0) begin
                        sda_oe_d = 1'b1;
                    end else if (ph_q == 2'h1) begin
                        scl_oe_d = 1'b0;
                    end else if (ph_q == 2'h2) begin
                        sda_oe_d = 1'b0;
                        state_d  = H_END;
                    end
                end
            end
            H_END: begin
                if (tick) begin
                    done_d  = 1'b1;
                    state_d = H_IDLE;
                end
            end
            default: begin
                state_d  = H_IDLE;
                scl_oe_d = 1'b0;
                sda_oe_d = 1'b0;
            end
        endcase
    end

    // State registers
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            state_q  <= H_IDLE;
            qcnt_q   <= 8'h00;
            ph_q     <= 2'h0;
            bit_q    <= 4'h0;
            pos_q    <= 4'h0;
            last_q   <= 4'h0;
            rd_q     <= 1'b0;
            sh_q     <= 9'h1FF;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
            done_q   <= 1'b0;
            nack_q   <= 1'b0;
            wbuf_q   <= 64'h0000_0000_0000_0000;
            rbuf_q   <= 64'h0000_0000_0000_0000;
        end else begin
            state_q  <= state_d;
            qcnt_q   <= qcnt_d;
            ph_q     <= ph_d;
            bit_q    <= bit_d;
            pos_q    <= pos_d;
            last_q   <= last_d;
            rd_q     <= rd_d;
            sh_q     <= sh_d;
            scl_oe_q <= scl_oe_d;
            sda_oe_q <= sda_oe_d;
            done_q   <= done_d;
            nack_q   <= nack_d;
            wbuf_q   <= wbuf_d;
            rbuf_q   <= rbuf_d;
        end
    end

    assign BUS.scl_host_oe = scl_oe_q;
    assign BUS.sda_host_oe = sda_oe_q;
    assign BUSY_OUT        = (state_q != H_IDLE);
    assign DONE_OUT        = done_q;
    assign NACK_OUT        = nack_q;
    assign RDATA_OUT       = rbuf_q;
endmodule

// File: dv/cfg_port_props.sv
// Assertions on the two-wire configuration bus between host and device.
// Assumes wired-AND lines, one clock and an active-low reset.
module cfg_port_props (
    input wire logic CLK_IN,
    input wire logic NRST_IN,
    input wire logic scl_host_oe,
    input wire logic sda_host_oe,
    input wire logic sda_dev_oe,
    input wire logic scl,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 100ps;
    // ------------------------------------------------------------
    // Bit period counter
    // ------------------------------------------------------------
    logic [15:0] per_q;
    logic [15:0] per_d;
    logic        scl_q;
    // Saturates so a long idle never wraps into a short period
    always_comb begin
        per_d = (per_q == 16'hFFFF) ? per_q : per_q + 16'h0001;
        if (scl && !scl_q) begin
            per_d = 16'h0000;
        end
    end
    // Registers only
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            per_q <= 16'hFFFF;
            scl_q <= 1'b1;
        end else begin
            per_q <= per_d;
            scl_q <= scl;
        end
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (!NRST_IN);
    // Frame edges: data moves while the clock stays high
    sequence start_seq;
        scl && $past(scl) && $fell(sda);
    endsequence
    sequence stop_seq;
        scl && $past(scl) && $rose(sda);
    endsequence
    idle_release_a: assert property ($rose(NRST_IN) |-> !scl_host_oe && !sda_host_oe && !sda_dev_oe)
        else $error("bus not released after reset");
    dev_sda_change_a: assert property ($changed(sda_dev_oe) |-> !scl)
        else $error("device moved data while clock high");
    dev_ack_delay_a: assert property ($rose(sda_dev_oe) |-> !$past(scl) && $past(scl, 6))
        else $error("device drive not just after clock fall");
    dev_ack_hold_a: assert property ($rose(scl) && sda_dev_oe |-> sda_dev_oe[*8])
        else $error("device dropped data during clock high");
    start_hold_a: assert property (start_seq |-> ##40 scl ##[1:15] !scl)
        else $error("clock low not about a quarter bit after start");
    stop_idle_a: assert property (stop_seq |-> (scl && sda)[*8])
        else $error("bus not idle after stop");
    scl_low_len_a: assert property ($fell(scl) |-> ##40 !scl ##[1:70] scl)
        else $error("clock low phase out of range");
    bit_rate_a: assert property (scl && !scl_q |-> per_q >= 16'h00C7)
        else $error("bit period under 10 us");
endmodule

// File: dv/clock_gen_serial_config_port_tb.sv
// Bench for both ends of the configuration port on one bus.
// Assumes a 20 MHz clock; a second bus lets the bench act as host by hand.
module clock_gen_serial_config_port_tb;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic        rd;
        logic [3:0]  len;
        logic [63:0] wd;
        logic [63:0] exp;
    } row_t;
    logic        clk;
    logic        nrst;
    logic        go;
    logic        rd;
    logic [3:0]  len;
    logic [63:0] wd;
    logic        busy;
    logic        done;
    logic        nack;
    logic [63:0] rdata;
    logic [63:0] cfg;
    logic        strobe;
    logic        ack_n;
    int          n_strobe;
    int          miscompares;
    int          n_compared;
    row_t        rows [4];
    logic [7:0]  addrs [3];
    cfg_port_if bus_if ();
    cfg_port_if aux_if ();
    // ------------------------------------------------------------
    // Ends under test, plus a lone device for hand-made frames
    // ------------------------------------------------------------
    cfg_port_host cfg_port_host_i (.CLK_IN(clk), .NRST_IN(nrst), .BUS(bus_if), .GO_IN(go), .READ_IN(rd),
        .LEN_IN(len), .WDATA_IN(wd), .BUSY_OUT(busy), .DONE_OUT(done), .NACK_OUT(nack), .RDATA_OUT(rdata));
    cfg_port_dev cfg_port_dev_i (.CLK_IN(clk), .NRST_IN(nrst), .BUS(bus_if), .CFG_OUT(cfg),
        .WR_STROBE_OUT(strobe));
    cfg_port_dev cfg_port_dev_aux_i (.CLK_IN(clk), .NRST_IN(nrst), .BUS(aux_if), .CFG_OUT(),
        .WR_STROBE_OUT());
    cfg_port_props cfg_port_props_i (.CLK_IN(clk), .NRST_IN(nrst), .scl_host_oe(bus_if.scl_host_oe),
        .sda_host_oe(bus_if.sda_host_oe), .sda_dev_oe(bus_if.sda_dev_oe), .scl(bus_if.scl), .sda(bus_if.sda));
    // Clock and stored-byte counter
    always #25 clk = ~clk;
    always @(negedge clk) begin
        if (strobe === 1'b1)
            n_strobe++;
    end
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check64(input string what, input logic [63:0] exp, input logic [63:0] got);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check1(input string what, input logic exp, input logic got);
        check64(what, {63'h0, exp}, {63'h0, got});
    endtask
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic qwait();
        repeat (cfg_port_pkg::QTR_CYC) @(negedge clk);
    endtask
    // Hold GO until taken; the wait is bounded so a hang ends the run
    task automatic run_host(input row_t r);
        int n;
        n = 0;
        rd = r.rd;
        len = r.len;
        wd = r.wd;
        go = 1'b1;
        while (busy !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        go = 1'b0;
        while (done !== 1'b1 && n < 30000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 30000) begin
            check1("done", 1'b1, done);
            end_of_test();
        end
    endtask
    // Start, one address byte with ack slot, stop; kept at 100 kbit/s
    task automatic aux_frame(input logic [7:0] a, output logic ack);
        logic [8:0] bits;
        bits = {a, 1'b1};
        aux_if.sda_host_oe = 1'b1;
        qwait();
        aux_if.scl_host_oe = 1'b1;
        for (int i = 8; i >= 0; i--) begin
            aux_if.sda_host_oe = ~bits[i];
            qwait();
            aux_if.scl_host_oe = 1'b0;
            qwait();
            ack = aux_if.sda;
            qwait();
            aux_if.scl_host_oe = 1'b1;
            qwait();
        end
        aux_if.sda_host_oe = 1'b1;
        qwait();
        aux_if.scl_host_oe = 1'b0;
        qwait();
        aux_if.sda_host_oe = 1'b0;
        qwait();
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        nrst = 1'b0;
        {go, rd, len, wd} = '0;
        aux_if.scl_host_oe = 1'b0;
        aux_if.sda_host_oe = 1'b0;
        n_strobe = 0;
        miscompares = 0;
        n_compared = 0;
        rows = '{'{1'b0, 4'h8, 64'h8877_6655_4433_2211, 64'h8877_6655_4433_2211},
                 '{1'b1, 4'h0, 64'h0, 64'h8877_6655_4433_2211},
                 '{1'b0, 4'h1, 64'hFFEE_DDCC_BBAA_9900, 64'h8877_6655_4433_2200},
                 '{1'b1, 4'h0, 64'h0, 64'h8877_6655_4433_2200}};
        addrs = '{8'hD0, 8'hA4, 8'hD2};
        repeat (6) @(negedge clk);
        nrst = 1'b1;
        check64("cfg at power-on", cfg_port_pkg::CFG_RESET, cfg);
        // Full write, read back, one-byte write, read back
        for (int i = 0; i < 4; i++) begin
            n_strobe = 0;
            run_host(rows[i]);
            repeat (2) @(negedge clk);
            check1("nack", 1'b0, nack);
            check1("busy after done", 1'b0, busy);
            // Reads must leave the latches and the strobe alone
            check64("cfg", rows[i].exp, cfg);
            check64("strobes", rows[i].rd ? 64'h0 : {60'h0, rows[i].len}, 64'(n_strobe));
            if (rows[i].rd) begin
                check64("read data", rows[i].exp, rdata);
            end
            $display("test %0d done", i);
        end
        // Reset in the middle of a write frame
        {rd, len, wd, go} = {1'b0, 4'h8, 64'h1234_5678_9ABC_DEF0, 1'b1};
        repeat (3000) @(negedge clk);
        nrst = 1'b0;
        go = 1'b0;
        repeat (6) @(negedge clk);
        check64("cfg in reset", cfg_port_pkg::CFG_RESET, cfg);
        check1("scl in reset", 1'b1, bus_if.scl);
        nrst = 1'b1;
        $display("test reset done");
        // Foreign addresses refused, own write address taken
        for (int i = 0; i < 3; i++) begin
            aux_frame(addrs[i], ack_n);
            check1("address ack", addrs[i] != cfg_port_pkg::WR_ADDR, ack_n);
        end
        $display("test address done");
        end_of_test();
    end
endmodule
